//--- csu_defines.svh
// register offsets, field positions, reset values and widths of the compare shadow block
`ifndef CSU_DEFINES_SVH
`define CSU_DEFINES_SVH

`define CSU_ADDR_W 8
`define CSU_DATA_W 32
`define CSU_CNT_W 16
`define CSU_CHAN_N 6

`define CSU_OFS_CTRL 8'h00
`define CSU_OFS_VALUE 8'h04
`define CSU_OFS_SHADOW 8'h08
`define CSU_OFS_STATUS 8'h0C

`define CSU_SEL_LSB 22
`define CSU_SEL_MSB 24
`define CSU_UPD_LSB 18
`define CSU_UPD_MSB 20
`define CSU_COC_BIT 17
`define CSU_PEND_BIT 0

`define CSU_SEL_RST 3'h0
`define CSU_UPD_RST 3'h0
`define CSU_COC_RST 1'b0
`define CSU_VAL_RST 16'h0000
`define CSU_LAST_SEL 3'h5

`endif

//--- csu_pkg.sv
// types shared by the compare shadow update block
`include "csu_defines.svh"

package csu_pkg;

	// update method codes of the control field
	typedef enum logic [2:0] {
		CSU_UPD_IMMEDIATE = 3'h0,
		CSU_UPD_ZERO = 3'h1,
		CSU_UPD_DOWN_MATCH = 3'h2,
		CSU_UPD_UP_MATCH = 3'h3,
		CSU_UPD_ZERO_LOAD = 3'h4,
		CSU_UPD_ZERO_REPEAT = 3'h5,
		CSU_UPD_TRIGGER = 3'h6,
		CSU_UPD_UNUSED = 3'h7
	} csu_method_type;

	// software-visible channel control fields
	typedef struct packed {
		logic [2:0] second_up_event_source_sel;
		csu_method_type update_method;
		logic capture_or_compare_sel;
	} csu_ctrl_type;

	// state of the timer that the channel watches
	typedef struct packed {
		logic [`CSU_CNT_W-1:0] counter_value;
		logic [`CSU_CNT_W-1:0] load_value;
		logic [`CSU_CNT_W-1:0] repeat_counter;
		logic count_down;
		logic trigger_pulse;
		logic capture_strobe;
	} csu_timer_type;

	// equality of counter and a reference, used for zero, load and match
	function automatic logic csu_equal(input logic [`CSU_CNT_W-1:0] a,
		input logic [`CSU_CNT_W-1:0] b);
		return a == b;
	endfunction

endpackage

//--- csu_event_select.sv
// chooses the timer event that moves the shadow compare value into the active register
`timescale 1ns/1ns
`include "csu_defines.svh"

module csu_event_select (
	// configuration
	input wire csu_pkg::csu_ctrl_type ctrl,
	// timer state and active compare value
	input wire csu_pkg::csu_timer_type timer_in,
	input wire logic [`CSU_CNT_W-1:0] compare_match_value,
	// events
	output logic down_compare_match_event,
	output logic up_compare_match_event,
	output logic update_event
);
	import csu_pkg::*;

	logic zero_hit;
	logic load_hit;
	logic match_hit;
	logic repeat_zero;

	// raw counter conditions
	always_comb begin
		zero_hit = csu_equal(timer_in.counter_value, `CSU_VAL_RST);
		load_hit = csu_equal(timer_in.counter_value, timer_in.load_value);
		match_hit = csu_equal(timer_in.counter_value, compare_match_value);
		repeat_zero = csu_equal(timer_in.repeat_counter, `CSU_VAL_RST);
	end

	// match events exist only while the register is a compare register
	always_comb begin
		down_compare_match_event = match_hit && timer_in.count_down &&
			!ctrl.capture_or_compare_sel;
		up_compare_match_event = match_hit && !timer_in.count_down &&
			!ctrl.capture_or_compare_sel;
	end

	// method decode; zero-or-load is also usable in down count, but meant for up/down
	always_comb begin
		case (ctrl.update_method)
			CSU_UPD_ZERO: update_event = zero_hit;
			CSU_UPD_DOWN_MATCH: update_event = down_compare_match_event;
			CSU_UPD_UP_MATCH: update_event = up_compare_match_event;
			CSU_UPD_ZERO_LOAD: update_event = zero_hit || load_hit;
			CSU_UPD_ZERO_REPEAT: update_event = zero_hit && repeat_zero;
			CSU_UPD_TRIGGER: update_event = timer_in.trigger_pulse;
			default: update_event = 1'b0;
		endcase
	end

endmodule

//--- csu_compare_shadow.sv
// one capture/compare channel value register with selectable shadow update
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns
`include "csu_defines.svh"

module csu_compare_shadow (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// register port
	input wire logic [`CSU_ADDR_W-1:0] reg_addr,
	input wire logic [`CSU_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [`CSU_DATA_W-1:0] reg_rdata,
	// timer state, same clock domain
	input wire csu_pkg::csu_timer_type timer_in,
	input wire logic [`CSU_CHAN_N-1:0] up_event_in,
	// channel outputs
	output logic [`CSU_CNT_W-1:0] compare_match_value,
	output logic down_compare_match_event,
	output logic up_compare_match_event,
	output logic second_up_event,
	output logic capture_or_compare_sel,
	output logic shadow_update_pulse
);
	import csu_pkg::*;

	// control register state
	csu_ctrl_type ctrl_q;
	csu_ctrl_type ctrl_d;

	// value register state
	logic [`CSU_CNT_W-1:0] active_q;
	logic [`CSU_CNT_W-1:0] active_d;
	logic [`CSU_CNT_W-1:0] shadow_q;
	logic [`CSU_CNT_W-1:0] shadow_d;
	logic pending_q;
	logic pending_d;
	logic upd_pulse_q;
	logic upd_pulse_d;

	// read answer state
	logic [`CSU_DATA_W-1:0] rdata_q;
	logic [`CSU_DATA_W-1:0] rdata_d;

	// decoded accesses
	// all of these are combinational and settle within the same cycle
	logic wr_ctrl;
	logic wr_value;
	logic shadowed_mode;
	logic update_event;
	logic do_transfer;

	// address decode of the write strobe
	// reads need no decode here; the read mux looks at the address itself
	always_comb begin
		wr_ctrl = reg_wr && (reg_addr == `CSU_OFS_CTRL);
		wr_value = reg_wr && (reg_addr == `CSU_OFS_VALUE);
	end

	// event selection lives in its own module
	// match events compare against the active value, never the staged one
	csu_event_select u_event_select (
		.ctrl(ctrl_q),
		.timer_in(timer_in),
		.compare_match_value(active_q),
		.down_compare_match_event(down_compare_match_event),
		.up_compare_match_event(up_compare_match_event),
		.update_event(update_event)
	);

	// staging only applies in compare mode with a non-immediate method
	// a capture register never stages, whatever the method field holds
	always_comb begin
		shadowed_mode = !ctrl_q.capture_or_compare_sel &&
			(ctrl_q.update_method != CSU_UPD_IMMEDIATE);
		do_transfer = shadowed_mode && pending_q && update_event;
	end

	// control register next value; unused method code 7h is stored as written
	// a write replaces all three fields; reserved bits of the word are dropped
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ctrl) begin
			ctrl_d.second_up_event_source_sel = reg_wdata[`CSU_SEL_MSB:`CSU_SEL_LSB];
			ctrl_d.update_method = csu_method_type'(reg_wdata[`CSU_UPD_MSB:`CSU_UPD_LSB]);
			ctrl_d.capture_or_compare_sel = reg_wdata[`CSU_COC_BIT];
		end
	end

	// control register flops
	// reset leaves the channel in compare mode with immediate update
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q.second_up_event_source_sel <= `CSU_SEL_RST;
			ctrl_q.update_method <= csu_method_type'(`CSU_UPD_RST);
			ctrl_q.capture_or_compare_sel <= `CSU_COC_RST;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// value register next state
	// the transfer uses the old shadow; a write in the same cycle stays pending,
	// so a new value is never lost behind an update that was already due
	// a capture strobe and a software write in one cycle: the write wins
	always_comb begin
		active_d = active_q;
		shadow_d = shadow_q;
		pending_d = pending_q;
		upd_pulse_d = 1'b0;
		if (do_transfer) begin
			active_d = shadow_q;
			pending_d = 1'b0;
			upd_pulse_d = 1'b1;
		end
		if (ctrl_q.capture_or_compare_sel) begin
			// capture register: timer strobe or software write, no staging
			pending_d = 1'b0;
			if (timer_in.capture_strobe) begin
				active_d = timer_in.counter_value;
			end
			if (wr_value) begin
				active_d = reg_wdata[`CSU_CNT_W-1:0];
			end
		end else if (wr_value) begin
			if (shadowed_mode) begin
				shadow_d = reg_wdata[`CSU_CNT_W-1:0];
				pending_d = 1'b1;
			end else begin
				active_d = reg_wdata[`CSU_CNT_W-1:0];
				shadow_d = reg_wdata[`CSU_CNT_W-1:0];
				pending_d = 1'b0;
			end
		end
		if (!shadowed_mode && !ctrl_q.capture_or_compare_sel && !wr_value) begin
			// leaving a staged method drops any write that never got its event
			pending_d = 1'b0;
		end
	end

	// value register flops
	// pending marks a shadow write that still waits for its event
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			active_q <= `CSU_VAL_RST;
			shadow_q <= `CSU_VAL_RST;
			pending_q <= 1'b0;
			upd_pulse_q <= 1'b0;
		end else begin
			active_q <= active_d;
			shadow_q <= shadow_d;
			pending_q <= pending_d;
			upd_pulse_q <= upd_pulse_d;
		end
	end

	// read mux; unmapped addresses and reserved bits read as zero
	// reads change no register, so a stray read strobe costs nothing
	always_comb begin
		rdata_d = '0;
		if (reg_rd) begin
			case (reg_addr)
				`CSU_OFS_CTRL: begin
					rdata_d[`CSU_SEL_MSB:`CSU_SEL_LSB] = ctrl_q.second_up_event_source_sel;
					rdata_d[`CSU_UPD_MSB:`CSU_UPD_LSB] = ctrl_q.update_method;
					rdata_d[`CSU_COC_BIT] = ctrl_q.capture_or_compare_sel;
				end
				`CSU_OFS_VALUE: begin
					rdata_d[`CSU_CNT_W-1:0] = active_q;
				end
				`CSU_OFS_SHADOW: begin
					rdata_d[`CSU_CNT_W-1:0] = shadow_q;
				end
				`CSU_OFS_STATUS: begin
					rdata_d[`CSU_PEND_BIT] = pending_q;
				end
				default: begin
					rdata_d = '0;
				end
			endcase
		end
	end

	// read data stands only in the cycle after the strobe
	// a flop here keeps the answer timing independent of the decode depth
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// second up event mux; codes 6h and 7h select nothing
	// the guard keeps codes above five from indexing past the six-bit vector
	always_comb begin
		second_up_event = 1'b0;
		if (ctrl_q.second_up_event_source_sel <= `CSU_LAST_SEL) begin
			second_up_event = up_event_in[ctrl_q.second_up_event_source_sel];
		end
	end

	// outputs
	// match events come straight from the selector, without a flop
	assign reg_rdata = rdata_q;
	assign compare_match_value = active_q;
	assign capture_or_compare_sel = ctrl_q.capture_or_compare_sel;
	assign shadow_update_pulse = upd_pulse_q;

endmodule

//--- csu_checker.sv
// port-level assertions for the compare shadow update block
`timescale 1ns/1ns
`include "csu_defines.svh"
module csu_checker (
	// clock and reset
	input logic core_clk,
	input logic rstn,
	// register port
	input logic [`CSU_ADDR_W-1:0] reg_addr,
	input logic [`CSU_DATA_W-1:0] reg_wdata,
	input logic reg_wr,
	input logic reg_rd,
	input logic [`CSU_DATA_W-1:0] reg_rdata,
	// timer and channel
	input csu_pkg::csu_timer_type timer_in,
	input logic [`CSU_CHAN_N-1:0] up_event_in,
	input logic [`CSU_CNT_W-1:0] compare_match_value,
	input logic down_compare_match_event,
	input logic up_compare_match_event,
	input logic second_up_event,
	input logic capture_or_compare_sel,
	input logic shadow_update_pulse
);
	import csu_pkg::*;

	// mirror layout: select in 7:5, reserved in 4, method in 3:1, mode in 0
	logic [7:0] ctl_q;
	logic [7:0] ctl_d;
	logic ev;
	logic z;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// mirror of control bits 24-17, seen only through bus writes
	always_comb begin
		ctl_d = ctl_q;
		if (reg_wr && reg_addr == `CSU_OFS_CTRL) begin
			ctl_d = reg_wdata[24:17];
		end
	end
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ctl_q <= 8'h00;
		end else begin
			ctl_q <= ctl_d;
		end
	end
	// event that the chosen method waits for
	assign z = timer_in.counter_value == 16'h0000;
	always_comb begin
		case (ctl_q[3:1])
			3'h1: ev = z;
			3'h2: ev = down_compare_match_event;
			3'h3: ev = up_compare_match_event;
			3'h4: ev = z || timer_in.counter_value == timer_in.load_value;
			3'h5: ev = z && timer_in.repeat_counter == 16'h0000;
			3'h6: ev = timer_in.trigger_pulse;
			default: ev = 1'b0;
		endcase
	end
	chk_second_sel: assert property (second_up_event ==
		(ctl_q[7:5] <= 3'h5 && up_event_in[ctl_q[7:5]])) else $error("second up event wrong");
	chk_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
		else $error("read data outside read slot");
	chk_immediate_wr: assert property (
		reg_wr && reg_addr == `CSU_OFS_VALUE && ctl_q[3:1] == 3'h0
		|=> compare_match_value == 16'($past(reg_wdata))) else $error("direct write lost");
	chk_update_cause: assert property (
		shadow_update_pulse |-> $past(ev) && !$past(capture_or_compare_sel))
		else $error("shadow moved without its event");
	chk_down_match: assert property (down_compare_match_event == (!capture_or_compare_sel &&
		timer_in.count_down && timer_in.counter_value == compare_match_value))
		else $error("down match wrong");
	chk_up_match: assert property (up_compare_match_event == (!capture_or_compare_sel &&
		!timer_in.count_down && timer_in.counter_value == compare_match_value))
		else $error("up match wrong");
	chk_coc_track: assert property (capture_or_compare_sel == ctl_q[0])
		else $error("mode bit does not follow control");
	chk_capture_quiet: assert property ($past(capture_or_compare_sel) |-> !shadow_update_pulse)
		else $error("shadow update in capture mode");
endmodule
bind csu_compare_shadow csu_checker chk (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .timer_in, .up_event_in, .compare_match_value, .down_compare_match_event,
	.up_compare_match_event, .second_up_event, .capture_or_compare_sel, .shadow_update_pulse);

//--- csu_testbench.sv
// self-checking bench for the compare shadow update block
`timescale 1ns/1ns
`include "csu_defines.svh"
module testbench;
	import csu_pkg::*;
	localparam csu_timer_type IDLE = '{16'h0123, 16'h0456, 16'h0001, 1'b0, 1'b0, 1'b0};
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] reg_addr = '0;
	logic [31:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [15:0] compare_match_value;
	logic shadow_update_pulse;
	csu_timer_type timer_in = IDLE;
	csu_timer_type t;
	logic [5:0] up_event_in = '0;
	logic [31:0] exp_q[$];
	logic [15:0] upd_q[$];
	logic [31:0] lf = 32'h41a0_62c9;
	logic [31:0] ctrl;
	logic [15:0] v;
	logic [15:0] act = 16'h0000;
	logic rd_q = 1'b0;
	int bad_count = 0;
	int total_checks = 0;
	int cyc = 0;
	csu_compare_shadow dut (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .timer_in, .up_event_in, .compare_match_value, .down_compare_match_event(),
		.up_compare_match_event(), .second_up_event(), .capture_or_compare_sel(),
		.shadow_update_pulse);
	initial forever #2 core_clk = ~core_clk;
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic report_and_stop;
		if (bad_count == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// one bus cycle; a read notes its expected data; random up events ride along
	task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] e);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
		lf = nxt(lf);
		up_event_in <= lf[5:0];
		if (r)
			exp_q.push_back(e);
		@(posedge core_clk);
	endtask
	task automatic tick(input csu_timer_type x);
		timer_in <= x;
		bus(1'b0, 1'b0, 8'h00, '0, '0);
	endtask
	// read data is due one edge after the strobe; also cuts a hang short
	always @(posedge core_clk) begin
		if (rd_q)
			chk("reg_rdata", exp_q.pop_front(), reg_rdata);
		// each update pulse must match a noted transfer and show its value
		if (shadow_update_pulse && upd_q.size() == 0)
			chk("shadow_update_pulse", 32'h0000_0000, 32'h0000_0001);
		else if (shadow_update_pulse)
			chk("compare_match_value", {16'h0000, upd_q.pop_front()},
				{16'h0000, compare_match_value});
		rd_q = reg_rd;
		cyc++;
		if (cyc == 2000) begin
			bad_count++;
			report_and_stop();
		end
	end
	initial begin
		repeat (20) @(posedge core_clk);
		rstn <= 1'b1;
		bus(1'b0, 1'b1, `CSU_OFS_CTRL, '0, 32'h0000_0000);
		bus(1'b0, 1'b1, 8'h10, '0, 32'h0000_0000);
		// every method code except unused 7h, two writes before the event so only the last may move
		for (int m = 0; m < 7; m++) begin
			v = {1'b1, lf[14:0]};
			// select 24:22, reserved 21, method 20:18, compare mode 17
			ctrl = {7'h00, 3'(m), 1'b0, 3'(m), 1'b0, 17'h0_0000};
			bus(1'b1, 1'b0, `CSU_OFS_CTRL, ctrl, '0);
			bus(1'b0, 1'b1, `CSU_OFS_CTRL, '0, ctrl);
			bus(1'b1, 1'b0, `CSU_OFS_VALUE, {16'h0000, ~v}, '0);
			bus(1'b1, 1'b0, `CSU_OFS_VALUE, {16'h0000, v}, '0);
			bus(1'b0, 1'b1, `CSU_OFS_VALUE, '0, {16'h0000, m == 0 ? v : act});
			t = IDLE;
			t.counter_value = m == 4 ? 16'h0456 : (m == 2 || m == 3) ? act : 16'h0000;
			// zero-or-load is only ever used while counting up
			t.count_down = m == 2;
			t.trigger_pulse = m == 6;
			if (m == 6)
				t.counter_value = 16'h0123;
			if (m == 5) begin
				tick(t);
				tick(IDLE);
				bus(1'b0, 1'b1, `CSU_OFS_VALUE, '0, {16'h0000, act});
				t.repeat_counter = 16'h0000;
			end
			if (m != 0)
				upd_q.push_back(v);
			tick(t);
			tick(IDLE);
			bus(1'b0, 1'b1, `CSU_OFS_VALUE, '0, {16'h0000, v});
			act = v;
		end
		// capture mode: writes land at once, zero events do nothing, strobe captures
		bus(1'b1, 1'b0, `CSU_OFS_CTRL, 32'h0006_0000, '0);
		bus(1'b1, 1'b0, `CSU_OFS_VALUE, 32'h0000_1234, '0);
		t = IDLE;
		t.counter_value = 16'h0000;
		tick(t);
		tick(IDLE);
		bus(1'b0, 1'b1, `CSU_OFS_VALUE, '0, 32'h0000_1234);
		t.counter_value = 16'h0777;
		t.capture_strobe = 1'b1;
		tick(t);
		tick(IDLE);
		bus(1'b0, 1'b1, `CSU_OFS_VALUE, '0, 32'h0000_0777);
		tick(IDLE);
		tick(IDLE);
		chk("update_count", 32'h0000_0000, 32'(upd_q.size()));
		report_and_stop();
	end
endmodule
